// ==== ppfs_pkg.sv ====
// Package with register map, field layout and pin mode codes for the port pin function select
package ppfs_pkg;
    localparam logic [7:0] PPFS_ADDR_P1_LOW  = 8'he3;
    localparam logic [7:0] PPFS_ADDR_P2_HIGH = 8'he4;
    localparam logic [7:0] PPFS_ADDR_P2_LOW  = 8'he5;
    localparam logic [7:0] PPFS_RESET_VALUE  = 8'h00;
    localparam logic [7:0] PPFS_P1_LOW_MASK  = 8'h0f;
    localparam int         PPFS_FIELD_W      = 2;
    localparam int         PPFS_P2_PINS      = 8;
    localparam int         PPFS_P1_PINS      = 2;
    localparam int         PPFS_TIMER_CLK_PIN = 2;
    localparam logic [1:0] PPFS_CODE_INPUT   = 2'h0;
    localparam logic [1:0] PPFS_CODE_ALT     = 2'h1;
    localparam logic [1:0] PPFS_CODE_OPEN    = 2'h2;
    localparam logic [1:0] PPFS_CODE_PUSH    = 2'h3;
    localparam logic [1:0] PPFS_P1_PULLUP    = 2'h1;
    localparam logic [1:0] PPFS_P1_ANALOG    = 2'h2;
endpackage

// ==== ppfs_pin_cell.sv ====
// One port two pin: decodes its mode field into pad controls
`timescale 1ns/100ps
module ppfs_pin_cell
    import ppfs_pkg::*;
#(
    parameter bit HAS_ALT = 1'b1
)
(
    input  wire logic [1:0] mode,
    input  wire logic       out_value,
    input  wire logic       alt_value,
    output logic            pad_out,
    output logic            pad_oe,
    output logic            in_enable
);
    wire logic use_alt = HAS_ALT && (mode == PPFS_CODE_ALT);
    wire logic drive   = use_alt ? alt_value : out_value;
    // Open drain drives only a low; code 01 on the timer clock pin is inert
    assign pad_out   = (mode == PPFS_CODE_OPEN) ? 1'b0 : drive;
    assign pad_oe    = (mode == PPFS_CODE_PUSH) || use_alt ||
                       ((mode == PPFS_CODE_OPEN) && !out_value);
    assign in_enable = (mode == PPFS_CODE_INPUT);
endmodule

// ==== ppfs_port_pin_function_select.sv ====
// Port one and port two pin function select registers and pad control
`timescale 1ns/100ps
//
// Contract
// - Port one low config sits at E3 in bank 1, bits 3..0 set pins 1 and 0, bits 7..4 unused.
// - Port one codes are input, input with pull-up, analog channel, push-pull output.
// - Port two high config sits at E4 in bank 1, four fields for pins 7 down to 4.
// - Port two low config sits at E5 in bank 1, four fields for pins 3 down to 0.
// - Port two codes are input (feeding receive or capture), alternate output, open drain, push-pull.
// - Pin two code 00 is input feeding the timer A clock, 01 is unavailable, 10/11 as other pins.
module ppfs_port_pin_function_select
    import ppfs_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       reg_bank1,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_hit,
    input  wire logic [1:0] port1_out,
    input  wire logic [1:0] port1_pad_in,
    output logic      [1:0] port1_pad_out,
    output logic      [1:0] port1_pad_oe,
    output logic      [1:0] port1_pullup_en,
    output logic      [1:0] port1_pin_in,
    output logic            analog_channel_eight_sel,
    output logic            analog_channel_nine_sel,
    input  wire logic [7:0] port2_out,
    input  wire logic [7:0] port2_pad_in,
    output logic      [7:0] port2_pad_out,
    output logic      [7:0] port2_pad_oe,
    output logic      [7:0] port2_pin_in,
    input  wire logic       serial0_transmit,
    input  wire logic       serial1_transmit,
    input  wire logic       timer_a_output,
    input  wire logic       timer_b_output,
    input  wire logic       timer0_output,
    output logic            serial0_receive,
    output logic            serial1_receive,
    output logic            timer_a_capture_input,
    output logic            timer_a_external_clock
);
    logic [7:0] p1_low_q;
    logic [7:0] p2_high_q;
    logic [7:0] p2_low_q;
    logic [1:0] p1_sync1_q;
    logic [1:0] p1_sync2_q;
    logic [7:0] p2_sync1_q;
    logic [7:0] p2_sync2_q;

    // Elaboration checks on the layout that the decode relies on
    if (PPFS_FIELD_W != 2)
    begin : g_chk_field
        $error("Mode fields must be two bits wide");
    end
    if (PPFS_P1_PINS * PPFS_FIELD_W > 8)
    begin : g_chk_p1
        $error("Port one fields do not fit one register");
    end
    if (PPFS_P2_PINS * PPFS_FIELD_W != 16)
    begin : g_chk_p2
        $error("Port two fields must fill two registers");
    end
    if (PPFS_TIMER_CLK_PIN >= PPFS_P2_PINS)
    begin : g_chk_clk
        $error("Timer clock pin lies outside port two");
    end
    if ((PPFS_P1_LOW_MASK >> (PPFS_P1_PINS * PPFS_FIELD_W)) != 8'h00)
    begin : g_chk_mask
        $error("Port one mask reaches unused bits");
    end
    if (PPFS_RESET_VALUE != 8'h00)
    begin : g_chk_reset
        $error("Configuration must clear to input mode");
    end
    if ((PPFS_P1_PULLUP == PPFS_P1_ANALOG) || (PPFS_P1_ANALOG == PPFS_CODE_PUSH))
    begin : g_chk_p1_codes
        $error("Port one mode codes overlap");
    end
    if ((PPFS_CODE_ALT == PPFS_CODE_INPUT) || (PPFS_CODE_OPEN == PPFS_CODE_PUSH))
    begin : g_chk_p2_codes
        $error("Port two mode codes overlap");
    end

    // Mode field of one pin within a configuration word
    function automatic logic [1:0] pin_field(input logic [15:0] cfg, input int pin);
        pin_field = cfg[pin*PPFS_FIELD_W +: PPFS_FIELD_W];
    endfunction

    // Peripheral input through a pin, idle level when the pin is not an input
    function automatic logic periph_in(input logic live, input logic level, input logic idle);
        periph_in = live ? level : idle;
    endfunction

    // Register decode
    wire logic sel_p1l = reg_bank1 && (reg_addr == PPFS_ADDR_P1_LOW);
    wire logic sel_p2h = reg_bank1 && (reg_addr == PPFS_ADDR_P2_HIGH);
    wire logic sel_p2l = reg_bank1 && (reg_addr == PPFS_ADDR_P2_LOW);

    // Write strobes per register
    wire logic wr_p1l = reg_wr && sel_p1l;
    wire logic wr_p2h = reg_wr && sel_p2h;
    wire logic wr_p2l = reg_wr && sel_p2l;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            p1_low_q <= PPFS_RESET_VALUE;
        else if (wr_p1l)
            p1_low_q <= reg_wdata & PPFS_P1_LOW_MASK;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            p2_high_q <= PPFS_RESET_VALUE;
        else if (wr_p2h)
            p2_high_q <= reg_wdata;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            p2_low_q <= PPFS_RESET_VALUE;
        else if (wr_p2l)
            p2_low_q <= reg_wdata;
    end

    // Read back, unused port one bits read zero
    assign reg_hit   = sel_p1l || sel_p2h || sel_p2l;
    assign reg_rdata = sel_p1l ? p1_low_q :
                       sel_p2h ? p2_high_q :
                       sel_p2l ? p2_low_q : 8'h00;

    // Port one pad synchroniser
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            p1_sync1_q <= 2'h0;
            p1_sync2_q <= 2'h0;
        end
        else
        begin
            p1_sync1_q <= port1_pad_in;
            p1_sync2_q <= p1_sync1_q;
        end
    end

    // Port two pad synchroniser
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            p2_sync1_q <= 8'h00;
            p2_sync2_q <= 8'h00;
        end
        else
        begin
            p2_sync1_q <= port2_pad_in;
            p2_sync2_q <= p2_sync1_q;
        end
    end

    // Port one pins
    wire logic [15:0] p1_modes = {8'h00, p1_low_q};
    wire logic [15:0] p2_modes = {p2_high_q, p2_low_q};
    genvar i;
    generate
        for (i = 0; i < PPFS_P1_PINS; i++)
        begin : g_p1
            wire logic [1:0] m   = pin_field(p1_modes, i);
            wire logic is_push   = (m == PPFS_CODE_PUSH);
            wire logic is_pullup = (m == PPFS_P1_PULLUP);
            wire logic in_mode   = (m == PPFS_CODE_INPUT) || is_pullup;
            assign port1_pad_out[i]   = port1_out[i];
            assign port1_pad_oe[i]    = is_push;
            assign port1_pullup_en[i] = is_pullup;
            assign port1_pin_in[i]    = in_mode & p1_sync2_q[i];
        end
    endgenerate
    assign analog_channel_eight_sel = (pin_field(p1_modes, 0) == PPFS_P1_ANALOG);
    assign analog_channel_nine_sel  = (pin_field(p1_modes, 1) == PPFS_P1_ANALOG);

    // Alternate outputs per port two pin, index is the pin number
    wire logic [7:0] p2_alt;
    assign p2_alt[7] = 1'b0;
    assign p2_alt[6] = serial0_transmit;
    assign p2_alt[5] = 1'b0;
    assign p2_alt[4] = serial1_transmit;
    assign p2_alt[3] = timer_a_output;
    assign p2_alt[2] = 1'b0;
    assign p2_alt[1] = timer_b_output;
    assign p2_alt[0] = timer0_output;
    wire logic [7:0] p2_in_en;

    // Port two pins
    generate
        for (i = 0; i < PPFS_P2_PINS; i++)
        begin : g_p2
            ppfs_pin_cell #(
                .HAS_ALT (i != PPFS_TIMER_CLK_PIN)
            ) u_cell (
                .mode      (pin_field(p2_modes, i)),
                .out_value (port2_out[i]),
                .alt_value (p2_alt[i]),
                .pad_out   (port2_pad_out[i]),
                .pad_oe    (port2_pad_oe[i]),
                .in_enable (p2_in_en[i])
            );
            assign port2_pin_in[i] = p2_in_en[i] & p2_sync2_q[i];
        end
    endgenerate

    // Peripheral inputs, idle high for receive lines when pin not in input mode
    assign serial0_receive        = periph_in(p2_in_en[7], p2_sync2_q[7], 1'b1);
    assign serial1_receive        = periph_in(p2_in_en[5], p2_sync2_q[5], 1'b1);
    assign timer_a_capture_input  = periph_in(p2_in_en[3], p2_sync2_q[3], 1'b0);
    assign timer_a_external_clock = periph_in(p2_in_en[2], p2_sync2_q[2], 1'b0);
endmodule

// ==== ppfs_sva.sv ====
// Assertion checker for the port pin function select
`timescale 1ns/100ps
module ppfs_sva
    import ppfs_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic       reg_bank1,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_hit,
    input wire logic [7:0] port2_pad_oe
);
    wire a3 = reg_bank1 && reg_addr == PPFS_ADDR_P1_LOW;
    wire a4 = reg_bank1 && reg_addr == PPFS_ADDR_P2_HIGH;
    wire a5 = reg_bank1 && reg_addr == PPFS_ADDR_P2_LOW;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_hit_decode: assert property (reg_hit == (a3 || a4 || a5))
        else $error("bad hit");
    a_miss_zero: assert property (!reg_hit |-> reg_rdata == 8'h00)
        else $error("bad miss read");
    a_upper_zero: assert property (a3 |-> reg_rdata[7:4] == 4'h0)
        else $error("bad upper bits");
    a_write_back: assert property (reg_wr && reg_hit
        ##1 $stable(reg_addr) && $stable(reg_bank1) |->
        reg_rdata == ($past(reg_wdata) & (a3 ? PPFS_P1_LOW_MASK : 8'hff))) else $error("bad write");
    a_push_pin: assert property (a5 && reg_rdata[7:6] == PPFS_CODE_PUSH |-> port2_pad_oe[3])
        else $error("bad push");
    a_clk_noalt: assert property (a5 && reg_rdata[5:4] == PPFS_CODE_ALT |-> !port2_pad_oe[2])
        else $error("bad pin two");
    a_reset_idle: assert property (disable iff (1'b0) sys_rst |=> port2_pad_oe == 8'h00)
        else $error("bad reset");
endmodule

bind ppfs_port_pin_function_select ppfs_sva u_sva (
    .sys_clk      (sys_clk),
    .sys_rst      (sys_rst),
    .reg_bank1    (reg_bank1),
    .reg_addr     (reg_addr),
    .reg_wr       (reg_wr),
    .reg_wdata    (reg_wdata),
    .reg_rdata    (reg_rdata),
    .reg_hit      (reg_hit),
    .port2_pad_oe (port2_pad_oe)
);

// ==== ppfs_port_pin_function_select_tb_top.sv ====
// Self-checking testbench for the port pin function select
`timescale 1ns/100ps
module ppfs_port_pin_function_select_tb_top;
    logic       sys_clk = 1'h0, sys_rst = 1'h1, reg_bank1 = 1'h1, reg_wr = 1'h0, reg_hit;
    logic       serial0_transmit = 1'h1, serial1_transmit = 1'h1, timer0_output = 1'h1;
    logic       timer_a_output = 1'h0, timer_b_output = 1'h0, serial0_receive, serial1_receive;
    logic       analog_channel_eight_sel, analog_channel_nine_sel, timer_a_capture_input;
    logic       timer_a_external_clock;
    logic [1:0] port1_out = 2'h0, port1_pad_in = 2'h3, port1_pad_out, port1_pad_oe;
    logic [1:0] port1_pullup_en, port1_pin_in;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, port2_out = 8'h00, port2_pad_in = 8'h7f;
    logic [7:0] reg_rdata, port2_pad_out, port2_pad_oe, port2_pin_in;
    int         fail_count = 0, samples_checked = 0, n = 0;
    ppfs_port_pin_function_select u_dut (
        .sys_clk                  (sys_clk),
        .sys_rst                  (sys_rst),
        .reg_bank1                (reg_bank1),
        .reg_addr                 (reg_addr),
        .reg_wr                   (reg_wr),
        .reg_wdata                (reg_wdata),
        .reg_rdata                (reg_rdata),
        .reg_hit                  (reg_hit),
        .port1_out                (port1_out),
        .port1_pad_in             (port1_pad_in),
        .port1_pad_out            (port1_pad_out),
        .port1_pad_oe             (port1_pad_oe),
        .port1_pullup_en          (port1_pullup_en),
        .port1_pin_in             (port1_pin_in),
        .analog_channel_eight_sel (analog_channel_eight_sel),
        .analog_channel_nine_sel  (analog_channel_nine_sel),
        .port2_out                (port2_out),
        .port2_pad_in             (port2_pad_in),
        .port2_pad_out            (port2_pad_out),
        .port2_pad_oe             (port2_pad_oe),
        .port2_pin_in             (port2_pin_in),
        .serial0_transmit         (serial0_transmit),
        .serial1_transmit         (serial1_transmit),
        .timer_a_output           (timer_a_output),
        .timer_b_output           (timer_b_output),
        .timer0_output            (timer0_output),
        .serial0_receive          (serial0_receive),
        .serial1_receive          (serial1_receive),
        .timer_a_capture_input    (timer_a_capture_input),
        .timer_a_external_clock   (timer_a_external_clock)
    );
    always #50 sys_clk = ~sys_clk;
    task automatic chk(logic [7:0] s, logic [7:0] e);
        samples_checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        @(negedge sys_clk);
        chk(reg_rdata, e);
    endtask
    task automatic summarize;
        $display("checked %0d failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        n <= n + 1;
        if (n == 3000)
        begin
            fail_count++;
            summarize();
        end
    end
    initial
    begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'h0;
        for (int i = 0; i < 3; i++) rd(8'he3 + 8'(i), 8'h00);
        $display("reset test done");
        wr(8'he3, 8'hff);
        rd(8'he3, 8'h0f);
        wr(8'he4, 8'ha5);
        rd(8'he4, 8'ha5);
        wr(8'he5, 8'h5a);
        rd(8'he5, 8'h5a);
        rd(8'he6, 8'h00);
        @(posedge sys_clk) reg_bank1 <= 1'h0;
        rd(8'he4, 8'h00);
        @(posedge sys_clk) reg_bank1 <= 1'h1;
        $display("register test done");
        for (int c = 0; c < 4; c++)
        begin
            wr(8'he3, {4'h0, {2{c[1:0]}}});
            wr(8'he5, {4{c[1:0]}});
            wr(8'he4, {4{c[1:0]}});
            @(negedge sys_clk);
            chk({port1_pad_oe[0], port1_pullup_en[0], analog_channel_eight_sel, port1_pin_in[0],
                port2_pad_oe[0], port2_pad_out[0], port2_pad_oe[2], timer_a_external_clock},
                {c == 3, c == 1, c == 2, c < 2, c != 0, c == 1, c > 1, c == 0});
            chk({5'h0, serial0_receive, port2_pad_out[6], port2_pad_oe[4]},
                {5'h0, c != 0, c == 1, c != 0});
        end
        $display("mode test done");
        @(posedge sys_clk);
        port1_out <= 2'h2;
        port2_out <= 8'h50;
        port2_pad_in <= 8'h5f;
        wr(8'he3, 8'h08);
        wr(8'he4, 8'haa);
        wr(8'he5, 8'h00);
        @(negedge sys_clk);
        chk({port1_pad_out, port1_pad_oe, port1_pin_in, analog_channel_nine_sel, reg_hit},
            {2'h2, 2'h0, 2'h1, 1'h1, 1'h1});
        chk(port2_pad_oe, 8'ha0);
        chk(port2_pad_out, 8'h00);
        chk(port2_pin_in, 8'h0f);
        chk({4'h0, serial0_receive, serial1_receive, timer_a_capture_input, timer_a_external_clock},
            {4'h0, 1'h1, 1'h1, 1'h1, 1'h1});
        wr(8'he4, 8'h00);
        wr(8'he5, 8'h10);
        @(negedge sys_clk);
        chk(port2_pin_in, 8'h5b);
        chk(port2_pad_oe, 8'h00);
        chk({4'h0, serial0_receive, serial1_receive, timer_a_capture_input, timer_a_external_clock},
            {4'h0, 1'h0, 1'h0, 1'h1, 1'h0});
        $display("pad test done");
        wr(8'he4, 8'hff);
        @(posedge sys_clk);
        sys_rst <= 1'h1;
        @(posedge sys_clk);
        sys_rst <= 1'h0;
        for (int i = 0; i < 3; i++) rd(8'he3 + 8'(i), 8'h00);
        chk(port2_pad_oe, 8'h00);
        $display("second reset test done");
        summarize();
    end
endmodule
